// *** shared/cbtd_pkg.sv ***
// constants and types for the compact branch and trap decoder
package cbtd_pkg;
    localparam int ADDR_W = 32;
    localparam logic [31:0] PREFETCH_BYTES = 32'h0000_0004;
    localparam logic [31:0] HALF_BYTES = 32'h0000_0002;
    localparam logic [31:0] TRAP_VECTOR = 32'h0000_0008;
    localparam logic [31:0] PC_RESET = 32'h0000_0000;
    localparam logic [31:0] LINK_RESET = 32'h0000_0000;
    localparam logic [4:0] MODE_SUPERVISOR = 5'h13;
    localparam logic [4:0] MODE_RESET = 5'h13;
    localparam logic [31:0] STATUS_RESET = 32'h0000_00d3;
    // instruction field positions
    localparam int COND_LSB = 8;
    localparam int H_BIT = 11;
    localparam int SHIFT_HIGH = 12;
    // major opcode values of the top bits
    localparam logic [3:0] OP_COND = 4'hd;
    localparam logic [4:0] OP_UNCOND = 5'h1c;
    localparam logic [3:0] OP_LONG = 4'hf;
    // condition codes
    localparam logic [3:0] CC_EQ = 4'h0;
    localparam logic [3:0] CC_NE = 4'h1;
    localparam logic [3:0] CC_CS = 4'h2;
    localparam logic [3:0] CC_CC = 4'h3;
    localparam logic [3:0] CC_MI = 4'h4;
    localparam logic [3:0] CC_PL = 4'h5;
    localparam logic [3:0] CC_VS = 4'h6;
    localparam logic [3:0] CC_VC = 4'h7;
    localparam logic [3:0] CC_HI = 4'h8;
    localparam logic [3:0] CC_LS = 4'h9;
    localparam logic [3:0] CC_GE = 4'ha;
    localparam logic [3:0] CC_LT = 4'hb;
    localparam logic [3:0] CC_GT = 4'hc;
    localparam logic [3:0] CC_LE = 4'hd;
    localparam logic [3:0] CC_UNDEF = 4'he;
    localparam logic [3:0] CC_TRAP = 4'hf;
    // status bit positions: n z c v at 31..28, state at 5, mode 4..0
    localparam int ST_N = 31;
    localparam int ST_Z = 30;
    localparam int ST_C = 29;
    localparam int ST_V = 28;
    localparam int ST_T = 5;
    typedef enum logic [2:0] {
        CBTD_NONE = 3'b000,
        CBTD_COND = 3'b001,
        CBTD_TRAP = 3'b010,
        CBTD_UNCOND = 3'b011,
        CBTD_LONG_HI = 3'b100,
        CBTD_LONG_LO = 3'b101,
        CBTD_UNDEF = 3'b110
    } cbtd_kind_t;
endpackage

// *** hdl/cbtd_cond_eval.sv ***
// condition code evaluator for conditional branches
`timescale 1ns/1ns
module cbtd_cond_eval
    import cbtd_pkg::*;
(
    input wire logic [3:0] cond,
    input wire logic flagN,
    input wire logic flagZ,
    input wire logic flagC,
    input wire logic flagV,
    output logic pass
);
    always_comb begin
        unique case (cond)
            CC_EQ: pass = flagZ;
            CC_NE: pass = !flagZ;
            CC_CS: pass = flagC;
            CC_CC: pass = !flagC;
            CC_MI: pass = flagN;
            CC_PL: pass = !flagN;
            CC_VS: pass = flagV;
            CC_VC: pass = !flagV;
            CC_HI: pass = flagC && !flagZ;
            CC_LS: pass = !flagC || flagZ;
            CC_GE: pass = flagN == flagV;
            CC_LT: pass = flagN != flagV;
            CC_GT: pass = !flagZ && (flagN == flagV);
            CC_LE: pass = flagZ || (flagN != flagV);
            // undefined and trap codes never branch here
            CC_UNDEF: pass = 1'b0;
            CC_TRAP: pass = 1'b0;
        endcase
    end
endmodule

// *** hdl/cbtd_decoder.sv ***
// branch and trap decode and execute for compressed instructions
`timescale 1ns/1ns
// Contract
// - targets use pc already four bytes ahead
// - 0000 z set, 0001 z clear
// - 0010 c set, 0011 c clear
// - 0100 n set, 0101 n clear
// - 0110 v set, 0111 v clear
// - 1000 c and not z; 1001 inverse
// - 1010 n equals v; 1011 differs
// - 1100 gt, 1101 le
// - conditional offset shifted left by one
// - condition 1111 is the software trap
// - trap saves link, status, vectors to supervisor
// - trap comment field ignored by hardware
// - unconditional offset eleven bits, shifted one
// - long first half: link gets pc plus high
module cbtd_decoder
    import cbtd_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic instrValid,
    input wire logic [15:0] instrHalf,
    input wire logic [31:0] instrAddr,
    input wire logic [31:0] statusIn,
    output logic isBranchKind,
    output logic [31:0] pcOut,
    output logic pcLoad,
    output logic [31:0] linkOut,
    output logic linkLoad,
    output logic [31:0] savedStatusOut,
    output logic savedStatusLoad,
    output logic [4:0] modeOut,
    output logic wideState,
    output logic undefTrap
);
    // ********************************
    // decode
    // ********************************
    cbtd_kind_t kind;
    logic [3:0] cond;
    logic condPass;
    logic [31:0] pcAhead;
    logic [31:0] nextHalf;
    logic [31:0] condOff;
    logic [31:0] uncondOff;
    logic [31:0] highOff;
    logic [31:0] lowOff;
    logic [31:0] linkReturn;
    logic [31:0] link_reg;
    logic [31:0] pc_reg;
    logic pcLoad_reg;
    logic linkLoad_reg;
    logic [31:0] savedStatus_reg;
    logic savedLoad_reg;
    logic [4:0] mode_reg;
    logic wide_reg;
    logic undef_reg;

    assign cond = instrHalf[COND_LSB +: 4];
    assign isBranchKind = instrValid && (kind != CBTD_NONE);

    always_comb begin
        kind = CBTD_NONE;
        if (instrHalf[15:12] == OP_COND) begin
            if (cond == CC_TRAP) begin
                kind = CBTD_TRAP;
            end else if (cond == CC_UNDEF) begin
                kind = CBTD_UNDEF;
            end else begin
                kind = CBTD_COND;
            end
        end else if (instrHalf[15:11] == OP_UNCOND) begin
            kind = CBTD_UNCOND;
        end else if (instrHalf[15:12] == OP_LONG) begin
            kind = instrHalf[H_BIT] ? CBTD_LONG_LO : CBTD_LONG_HI;
        end
    end

    cbtd_cond_eval condEval (
        .cond(cond),
        .flagN(statusIn[ST_N]),
        .flagZ(statusIn[ST_Z]),
        .flagC(statusIn[ST_C]),
        .flagV(statusIn[ST_V]),
        .pass(condPass)
    );

    // ********************************
    // instruction fields
    // ********************************
    // one slice point per field so every offset sees the same bits
    logic [7:0] condBranchOffsetField;
    logic [10:0] longOffsetField;
    assign condBranchOffsetField = instrHalf[7:0];
    assign longOffsetField = instrHalf[10:0];

    // ********************************
    // address arithmetic
    // ********************************
    assign pcAhead = instrAddr + PREFETCH_BYTES;
    assign nextHalf = instrAddr + HALF_BYTES;
    // sign extend, then shift
    assign condOff = {{23{condBranchOffsetField[7]}},
        condBranchOffsetField, 1'b0};
    assign uncondOff = {{20{longOffsetField[10]}},
        longOffsetField, 1'b0};
    assign highOff = {{9{longOffsetField[10]}},
        longOffsetField, 12'h000};
    // low half unsigned: the high half already carries the sign
    assign lowOff = {20'h00000, longOffsetField, 1'b0};
    // bit 0 set marks a return into the compressed state
    assign linkReturn = {nextHalf[31:1], 1'b1};

    // ********************************
    // program counter
    // ********************************
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pc_reg <= PC_RESET;
            pcLoad_reg <= 1'b0;
        end else begin
            pcLoad_reg <= 1'b0;
            if (instrValid) begin
                unique case (kind)
                    CBTD_COND: begin
                        // fail falls through by leaving pc to fetch
                        pcLoad_reg <= condPass;
                        pc_reg <= pcAhead + condOff;
                    end
                    CBTD_TRAP: begin
                        pcLoad_reg <= 1'b1;
                        pc_reg <= TRAP_VECTOR;
                    end
                    CBTD_UNCOND: begin
                        pcLoad_reg <= 1'b1;
                        pc_reg <= pcAhead + uncondOff;
                    end
                    CBTD_LONG_LO: begin
                        pcLoad_reg <= 1'b1;
                        pc_reg <= link_reg + lowOff;
                    end
                    CBTD_LONG_HI, CBTD_UNDEF, CBTD_NONE: begin
                        // first half only writes link; fetch moves on
                        pcLoad_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ********************************
    // link register
    // ********************************
    // link held here so a second half sees the first half's sum
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            link_reg <= LINK_RESET;
            linkLoad_reg <= 1'b0;
        end else begin
            linkLoad_reg <= 1'b0;
            if (instrValid) begin
                if (kind == CBTD_TRAP) begin
                    link_reg <= nextHalf;
                    linkLoad_reg <= 1'b1;
                end else if (kind == CBTD_LONG_HI) begin
                    link_reg <= pcAhead + highOff;
                    linkLoad_reg <= 1'b1;
                end else if (kind == CBTD_LONG_LO) begin
                    link_reg <= linkReturn;
                    linkLoad_reg <= 1'b1;
                end
            end
        end
    end

    // ********************************
    // status and mode
    // ********************************
    // comment field bits 7..0 reach no logic for the trap
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            savedStatus_reg <= STATUS_RESET;
            savedLoad_reg <= 1'b0;
            mode_reg <= MODE_RESET;
            wide_reg <= 1'b1;
        end else begin
            savedLoad_reg <= 1'b0;
            if (instrValid && kind == CBTD_TRAP) begin
                savedStatus_reg <= statusIn;
                savedLoad_reg <= 1'b1;
                mode_reg <= MODE_SUPERVISOR;
                wide_reg <= 1'b1;
            end else begin
                mode_reg <= statusIn[4:0];
                wide_reg <= !statusIn[ST_T];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            undef_reg <= 1'b0;
        end else begin
            undef_reg <= instrValid && (kind == CBTD_UNDEF);
        end
    end

    assign pcOut = pc_reg;
    assign pcLoad = pcLoad_reg;
    assign linkOut = link_reg;
    assign linkLoad = linkLoad_reg;
    assign savedStatusOut = savedStatus_reg;
    assign savedStatusLoad = savedLoad_reg;
    assign modeOut = mode_reg;
    assign wideState = wide_reg;
    assign undefTrap = undef_reg;
endmodule

// *** sim/cbtd_fetch_model.sv ***
// fetch stage model feeding halfwords and status flags
`timescale 1ns/1ns
module cbtd_fetch_model (
    input wire logic mclk,
    output logic instrValid,
    output logic [15:0] instrHalf,
    output logic [31:0] instrAddr,
    output logic [31:0] statusIn
);
    // ****************
    // request side
    // ****************
    initial begin
        instrValid = 1'b0;
        instrHalf = 16'h0000;
        instrAddr = 32'h0000_0000;
        statusIn = 32'h0000_0000;
    end
    // entered at a falling edge, held across exactly one rising edge
    task automatic issue(input logic [15:0] h, input logic [31:0] a,
                         input logic [31:0] s);
        instrValid = 1'b1;
        instrHalf = h;
        instrAddr = a;
        statusIn = s;
        @(negedge mclk);
    endtask
    // released lines inverted so a stale value is never trusted
    task automatic idle();
        instrValid = 1'b0;
        instrHalf = ~instrHalf;
        instrAddr = ~instrAddr;
        statusIn = ~statusIn;
        @(negedge mclk);
    endtask
endmodule

// *** sim/cbtd_decoder_checker.sv ***
// assertions on the branch and trap decoder ports
`timescale 1ns/1ns
module cbtd_decoder_checker
    import cbtd_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic instrValid,
    input wire logic [15:0] instrHalf,
    input wire logic [31:0] instrAddr,
    input wire logic [31:0] statusIn,
    input wire logic isBranchKind,
    input wire logic [31:0] pcOut,
    input wire logic pcLoad,
    input wire logic [31:0] linkOut,
    input wire logic linkLoad,
    input wire logic [31:0] savedStatusOut,
    input wire logic savedStatusLoad,
    input wire logic [4:0] modeOut,
    input wire logic wideState,
    input wire logic undefTrap
);
    // ****************
    // targets and sequences
    // ****************
    logic [15:0] h;
    logic [31:0] condT, uncT, hiT, loT;
    assign h = instrHalf;
    assign condT = instrAddr + PREFETCH_BYTES + {{23{h[7]}}, h[7:0], 1'b0};
    assign uncT = instrAddr + PREFETCH_BYTES + {{20{h[10]}}, h[10:0], 1'b0};
    assign hiT = instrAddr + PREFETCH_BYTES + {{9{h[10]}}, h[10:0], 12'h0};
    assign loT = linkOut + {20'h0, h[10:0], 1'b0};
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence trapReq;
        instrValid && h[15:8] == 8'hdf;
    endsequence
    sequence condReq;
        instrValid && h[15:12] == OP_COND && h[11:9] != 3'b111;
    endsequence
    sequence longHi;
        instrValid && h[15:11] == 5'h1e;
    endsequence
    sequence longLo;
        instrValid && h[15:11] == 5'h1f;
    endsequence
    sequence uncondReq;
        instrValid && h[15:11] == OP_UNCOND;
    endsequence
    trap_vector_a: assert property (trapReq |=>
        pcLoad && pcOut == TRAP_VECTOR) else $error("bad trap vector");
    trap_link_a: assert property (trapReq |=>
        linkLoad && linkOut == $past(instrAddr) + HALF_BYTES)
        else $error("bad trap link");
    trap_state_a: assert property (trapReq |=> savedStatusLoad &&
        savedStatusOut == $past(statusIn) && modeOut == MODE_SUPERVISOR
        && wideState) else $error("bad trap state");
    undef_skip_a: assert property (instrValid && h[15:8] == 8'hde |=>
        undefTrap && !pcLoad) else $error("undefined code branched");
    cond_eq_a: assert property (instrValid && h[15:8] == 8'hd0 |=>
        pcLoad == $past(statusIn[ST_Z])) else $error("bad equal branch");
    cond_target_a: assert property (condReq ##1 pcLoad |->
        pcOut == $past(condT)) else $error("bad cond target");
    uncond_target_a: assert property (uncondReq |=>
        pcLoad && pcOut == $past(uncT)) else $error("bad uncond target");
    long_high_a: assert property (longHi |=>
        linkLoad && linkOut == $past(hiT)) else $error("bad long high");
    long_low_a: assert property (longLo |=> pcLoad &&
        pcOut == $past(loT) && linkOut == ($past(instrAddr) + 32'h2 | 32'h1))
        else $error("bad long low");
endmodule
bind cbtd_decoder cbtd_decoder_checker chk (.mclk, .rst_b, .instrValid,
    .instrHalf, .instrAddr, .statusIn, .isBranchKind, .pcOut, .pcLoad,
    .linkOut, .linkLoad, .savedStatusOut, .savedStatusLoad, .modeOut,
    .wideState, .undefTrap);

// *** sim/testbench.sv ***
// self-checking bench for the branch and trap decoder
`timescale 1ns/1ns
module testbench;
    import cbtd_pkg::*;
    logic mclk, rst_b, instrValid, pcLoad, linkLoad, savedStatusLoad;
    logic isBranchKind, wideState, undefTrap;
    logic [15:0] instrHalf;
    logic [31:0] instrAddr, statusIn, pcOut, linkOut, savedStatusOut;
    logic [4:0] modeOut;
    int mismatches, checks, cycles;
    // ****************
    // harness
    // ****************
    cbtd_fetch_model fetch (.mclk, .instrValid, .instrHalf, .instrAddr,
        .statusIn);
    cbtd_decoder dut (.mclk, .rst_b, .instrValid, .instrHalf, .instrAddr,
        .statusIn, .isBranchKind, .pcOut, .pcLoad, .linkOut, .linkLoad,
        .savedStatusOut, .savedStatusLoad, .modeOut, .wideState, .undefTrap);
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // own reading of the flags, f is n z c v
    function automatic logic condOk(input logic [3:0] c, input logic [3:0] f);
        logic r;
        case (c[3:1])
            3'd0: r = f[2];
            3'd1: r = f[1];
            3'd2: r = f[3];
            3'd3: r = f[0];
            3'd4: r = f[1] & ~f[2];
            3'd5: r = f[3] == f[0];
            default: r = ~f[2] & (f[3] == f[0]);
        endcase
        return r ^ c[0];
    endfunction
    // ****************
    // scenarios
    // ****************
    task automatic test_cond();
        logic p;
        logic [31:0] ld, want, tgt;
        for (int c = 0; c < 14; c++) begin
            for (int f = 0; f < 16; f++) begin
                fetch.issue({4'hd, c[3:0], f[0] ? 8'h80 : 8'h7f},
                    32'h0000_1000, {f[3:0], 28'h0});
                p = condOk(c[3:0], f[3:0]);
                ld = {31'h0, pcLoad};
                want = {31'h0, p};
                tgt = f[0] ? 32'h0000_0f04 : 32'h0000_1102;
                if (c < 2) chk("cond z", ld, want);
                else if (c < 4) chk("cond c", ld, want);
                else if (c < 6) chk("cond n", ld, want);
                else if (c < 8) chk("cond v", ld, want);
                else if (c < 10) chk("cond hi", ld, want);
                else if (c < 12) chk("cond ge", ld, want);
                else chk("cond gt", ld, want);
                if (p) chk("cond pc", pcOut, tgt);
            end
        end
        fetch.idle();
    endtask
    task automatic test_trap();
        logic [31:0] a, s;
        for (int k = 0; k < 2; k++) begin
            a = (k == 0) ? 32'h0000_2000 : 32'h0000_2ffe;
            s = (k == 0) ? 32'ha000_0030 : 32'h5000_003f;
            fetch.issue({8'hdf, {8{k[0]}}}, a, s);
            chk("trap pulses", {30'h0, pcLoad, linkLoad}, 32'h3);
            chk("trap pc", pcOut, TRAP_VECTOR);
            chk("trap link", linkOut, a + HALF_BYTES);
            chk("trap saved", savedStatusOut, s);
            chk("trap mode", {27'h0, modeOut}, 32'(MODE_SUPERVISOR));
            chk("trap state", {31'h0, wideState}, 32'h1);
        end
        fetch.idle();
    endtask
    task automatic test_uncond();
        fetch.issue({5'h1c, 11'h3ff}, 32'h0000_8000, 32'h0);
        chk("uncond fwd", pcOut, 32'h8802);
        fetch.issue({5'h1c, 11'h400}, 32'h0000_8000, 32'h0);
        chk("uncond back", pcOut, 32'h7804);
        fetch.idle();
    endtask
    task automatic test_long();
        fetch.issue({5'h1e, 11'h7ff}, 32'h0001_0000, 32'h0);
        chk("long high", linkOut, 32'h0f004);
        fetch.issue({5'h1f, 11'h001}, 32'h0001_0002, 32'h0);
        chk("long pc", pcOut, 32'h0f006);
        chk("long link", linkOut, 32'h10005);
        fetch.idle();
    endtask
    task automatic test_refuse();
        fetch.issue(16'hde00, 32'h0000_3000, 32'h0);
        chk("undef kind", {31'h0, isBranchKind}, 32'h1);
        chk("undef", {30'h0, undefTrap, pcLoad}, 32'h2);
        fetch.issue(16'h4000, 32'h0000_3002, 32'h0);
        chk("plain kind", {31'h0, isBranchKind}, 32'h0);
        chk("plain", {30'h0, undefTrap, pcLoad}, 32'h0);
        fetch.idle();
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            final_report();
        end
    end
    initial begin
        rst_b = 1'b0;
        repeat (6) @(negedge mclk);
        chk("reset pc", pcOut, PC_RESET);
        chk("reset saved", savedStatusOut, STATUS_RESET);
        rst_b = 1'b1;
        test_cond();
        test_trap();
        test_uncond();
        test_long();
        test_refuse();
        final_report();
    end
endmodule
